// ===== pwm_defines.vh
// Purpose: Shared constants for the PWM duty compare and counter readback block
// Assumes: APB slave with byte addresses, 32-bit data, one clock
// Notes:   Definitions only; included by bare name
//
// What this block does
// - Per-channel writable 16-bit compare, upper bits reserved
// - Frequency is clock over prescale+1, divider, reload+1
// - Compare at or above reload keeps output high
// - Low reload-compare cycles, high compare+1 cycles
// - Compare writes apply from the next period
// - Read-only register returns live down counter
// - Compat bit zero selects behaviour, resets clear
// - Reload value sets period, counter runs down
`ifndef PWM_DEFINES_VH
`define PWM_DEFINES_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_PRESCALE      8'h00
`define OFS_DIVIDER       8'h04
`define OFS_RUN           8'h08
`define OFS_RELOAD_CH0    8'h0c
`define OFS_COMPARE_CH0   8'h10
`define OFS_SNAPSHOT_CH0  8'h14
`define OFS_RELOAD_CH1    8'h18
`define OFS_COMPARE_CH1   8'h1c
`define OFS_SNAPSHOT_CH1  8'h20
`define OFS_RELOAD_CH2    8'h24
`define OFS_COMPARE_CH2   8'h28
`define OFS_SNAPSHOT_CH2  8'h2c
`define OFS_RELOAD_CH3    8'h30
`define OFS_COMPARE_CH3   8'h34
`define OFS_SNAPSHOT_CH3  8'h38
`define OFS_COMPAT        8'h3c

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define VAL_MSB           15
`define PRESC_W           8
`define PRESC_P0_LSB      0
`define PRESC_P1_LSB      8
`define DIV_W             3
`define DIV_STRIDE        4
`define COMPAT_BIT        0
`define RST_VAL16         16'h0000
`define RST_PRESC         8'h00
`define RST_DIV           3'h0
`define RST_WORD          32'h0000_0000

// ****************************************************************
// Clock divider selections and their last count
// ****************************************************************
`define DIV_SEL_1         3'h0
`define DIV_SEL_2         3'h1
`define DIV_SEL_4         3'h2
`define DIV_SEL_8         3'h3
`define DIV_SEL_16        3'h4
`define DIV_LAST_1        4'h0
`define DIV_LAST_2        4'h1
`define DIV_LAST_4        4'h3
`define DIV_LAST_8        4'h7
`define DIV_LAST_16       4'hf

`endif

// ===== pwm_channel_core.v
// Purpose: One PWM channel: clock divider, down counter, compare and output
// Assumes: presc_tick is a one-cycle enable from the pair prescaler
// Notes:   Compare and reload are staged into the running period at its end
`timescale 1ns/10ps
`include "pwm_defines.vh"

module pwm_channel_core (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        run,
    input  wire        presc_tick,
    input  wire [2:0]  div_sel,
    input  wire [15:0] reload_val,
    input  wire [15:0] compare_val,
    output wire [15:0] count_val,
    output wire        pwm_out
);

    // ****************************************************************
    // Divider decode
    // ****************************************************************
    // Last count of the divider for a selection
    function [3:0] div_last;
        input [2:0] sel;
        begin
            case (sel)
                `DIV_SEL_2:  div_last = `DIV_LAST_2;
                `DIV_SEL_4:  div_last = `DIV_LAST_4;
                `DIV_SEL_8:  div_last = `DIV_LAST_8;
                `DIV_SEL_16: div_last = `DIV_LAST_16;
                default:     div_last = `DIV_LAST_1;
            endcase
        end
    endfunction

    reg [3:0]  div_cnt_ff;     // Divider count of prescaled ticks
    reg [15:0] cnt_ff;         // Down counter
    reg [15:0] cmp_act_ff;     // Compare in force this period
    reg        run_d_ff;       // Run delayed, for start edge
    reg        pwm_ff;         // Registered output
    reg [15:0] nxt_cnt;        // Next counter
    reg [15:0] nxt_cmp;        // Next active compare
    wire       pwm_tick;       // One PWM clock cycle
    wire       start;          // Run just enabled

    assign pwm_tick  = run & presc_tick & (div_cnt_ff == div_last(div_sel));
    assign start     = run & ~run_d_ff;
    assign count_val = cnt_ff;
    assign pwm_out   = pwm_ff;

    // ****************************************************************
    // Counter next state
    // ****************************************************************
    // Reload and compare taken only at a period boundary
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_cmp = cmp_act_ff;
        if (start) begin
            // Fresh start loads both
            nxt_cnt = reload_val;
            nxt_cmp = compare_val;
        end else if (pwm_tick) begin
            if (cnt_ff == `RST_VAL16) begin
                // Period end: new values apply
                nxt_cnt = reload_val;
                nxt_cmp = compare_val;
            end else begin
                // Count down
                nxt_cnt = cnt_ff - 16'h0001;
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Divider, counter, compare and output flops
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt_ff <= 4'h0;
            cnt_ff     <= `RST_VAL16;
            cmp_act_ff <= `RST_VAL16;
            run_d_ff   <= 1'b0;
            pwm_ff     <= 1'b0;
        end else begin
            run_d_ff   <= run;
            cnt_ff     <= nxt_cnt;
            cmp_act_ff <= nxt_cmp;
            if (!run) begin
                // Stopped: divider restarts
                div_cnt_ff <= 4'h0;
            end else if (presc_tick) begin
                // Advance or wrap the divider
                div_cnt_ff <= pwm_tick ? 4'h0 : div_cnt_ff + 4'h1;
            end
            // High at or below compare; covers full-high case
            pwm_ff <= run & (nxt_cnt <= nxt_cmp);
        end
    end

endmodule // pwm_channel_core

// ===== pwm_duty_compare_readback.v
// Purpose: Four-channel PWM group with compare, reload and counter readback
// Assumes: APB slave on clk_sys, zero wait states after the setup cycle
// Notes:   Pair 0 is channels 0-1, pair 1 is channels 2-3
`timescale 1ns/10ps
`include "pwm_defines.vh"

module pwm_duty_compare_readback #(
    parameter NUM_CH = 4
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire [3:0]  pwm_out,
    output wire        compat_mode_bit
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [15:0] cmp_ff [0:3];        // Duty compare values
    reg  [15:0] rld_ff [0:3];        // Period reload values
    reg  [7:0]  presc_ff [0:1];      // Prescale per pair
    reg  [2:0]  div_ff [0:3];        // Divider select per channel
    reg  [3:0]  run_ff;              // Channel run bits
    reg         compat_ff;           // Compatibility select
    reg  [7:0]  presc_cnt_ff [0:1];  // Prescaler counters
    reg  [31:0] prdata_ff;           // Read data
    reg         pready_ff;           // Access phase ready
    reg         pslverr_ff;          // Unmapped address error
    reg  [31:0] nxt_rdata;           // Read mux result
    reg         nxt_hit;             // Address decodes
    wire [1:0]  presc_tick;          // Prescaled enable per pair
    wire [15:0] cnt_val [0:3];       // Live counters
    wire        setup;               // Setup cycle of a transfer
    wire        wr_go;               // Write commits this edge
    integer     i;                   // Loop index

    assign setup           = psel & ~penable;
    assign wr_go           = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign compat_mode_bit = compat_ff;

    // ****************************************************************
    // Address helpers
    // ****************************************************************
    // Channel of a per-channel offset
    function [1:0] ch_of;
        input [7:0] a;
        begin
            case (a)
                `OFS_RELOAD_CH1, `OFS_COMPARE_CH1, `OFS_SNAPSHOT_CH1: ch_of = 2'h1;
                `OFS_RELOAD_CH2, `OFS_COMPARE_CH2, `OFS_SNAPSHOT_CH2: ch_of = 2'h2;
                `OFS_RELOAD_CH3, `OFS_COMPARE_CH3, `OFS_SNAPSHOT_CH3: ch_of = 2'h3;
                default:                                              ch_of = 2'h0;
            endcase
        end
    endfunction

    // Offset is a duty compare register
    function is_cmp;
        input [7:0] a;
        begin
            is_cmp = (a == `OFS_COMPARE_CH0) | (a == `OFS_COMPARE_CH1) |
                     (a == `OFS_COMPARE_CH2) | (a == `OFS_COMPARE_CH3);
        end
    endfunction

    // Offset is a period reload register
    function is_rld;
        input [7:0] a;
        begin
            is_rld = (a == `OFS_RELOAD_CH0) | (a == `OFS_RELOAD_CH1) |
                     (a == `OFS_RELOAD_CH2) | (a == `OFS_RELOAD_CH3);
        end
    endfunction

    // Offset is a counter snapshot register
    function is_snap;
        input [7:0] a;
        begin
            is_snap = (a == `OFS_SNAPSHOT_CH0) | (a == `OFS_SNAPSHOT_CH1) |
                      (a == `OFS_SNAPSHOT_CH2) | (a == `OFS_SNAPSHOT_CH3);
        end
    endfunction

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Reserved bits read zero; narrow fields sit low
    always @* begin
        nxt_rdata = `RST_WORD;
        nxt_hit   = 1'b1;
        if (is_cmp(paddr)) begin
            // Compare in low half
            nxt_rdata[`VAL_MSB:0] = cmp_ff[ch_of(paddr)];
        end else if (is_rld(paddr)) begin
            // Reload in low half
            nxt_rdata[`VAL_MSB:0] = rld_ff[ch_of(paddr)];
        end else if (is_snap(paddr)) begin
            // Live down counter
            nxt_rdata[`VAL_MSB:0] = cnt_val[ch_of(paddr)];
        end else begin
            case (paddr)
                `OFS_PRESCALE: begin
                    // Both pair prescales
                    nxt_rdata[`PRESC_P0_LSB +: `PRESC_W] = presc_ff[0];
                    nxt_rdata[`PRESC_P1_LSB +: `PRESC_W] = presc_ff[1];
                end
                `OFS_DIVIDER: begin
                    // Divider selects, one nibble each
                    for (i = 0; i < 4; i = i + 1) begin
                        nxt_rdata[i*`DIV_STRIDE +: `DIV_W] = div_ff[i];
                    end
                end
                `OFS_RUN: begin
                    // Run bits
                    nxt_rdata[3:0] = run_ff;
                end
                `OFS_COMPAT: begin
                    // Compatibility bit
                    nxt_rdata[`COMPAT_BIT] = compat_ff;
                end
                default: begin
                    // Unmapped
                    nxt_hit = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // APB handshake
    // ****************************************************************
    // Answer is ready in the access cycle right after setup
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_ff  <= `RST_WORD;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~nxt_hit;
            if (setup & ~pwrite) begin
                // Snapshot taken at setup
                prdata_ff <= nxt_rdata;
            end else if (!psel) begin
                // Idle bus reads zero
                prdata_ff <= `RST_WORD;
            end
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Writes commit on the access edge; snapshots ignore writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (i = 0; i < 4; i = i + 1) begin
                cmp_ff[i] <= `RST_VAL16;
                rld_ff[i] <= `RST_VAL16;
                div_ff[i] <= `RST_DIV;
            end
            presc_ff[0] <= `RST_PRESC;
            presc_ff[1] <= `RST_PRESC;
            run_ff      <= 4'h0;
            compat_ff   <= 1'b0;
        end else if (wr_go) begin
            if (is_cmp(paddr)) begin
                // Staged; channel picks it up at period end
                cmp_ff[ch_of(paddr)] <= pwdata[`VAL_MSB:0];
            end else if (is_rld(paddr)) begin
                // Staged reload value
                rld_ff[ch_of(paddr)] <= pwdata[`VAL_MSB:0];
            end else begin
                case (paddr)
                    `OFS_PRESCALE: begin
                        // Pair prescales
                        presc_ff[0] <= pwdata[`PRESC_P0_LSB +: `PRESC_W];
                        presc_ff[1] <= pwdata[`PRESC_P1_LSB +: `PRESC_W];
                    end
                    `OFS_DIVIDER: begin
                        // Divider selects
                        for (i = 0; i < 4; i = i + 1) begin
                            div_ff[i] <= pwdata[i*`DIV_STRIDE +: `DIV_W];
                        end
                    end
                    `OFS_RUN: begin
                        // Start or stop channels
                        run_ff <= pwdata[3:0];
                    end
                    `OFS_COMPAT: begin
                        // Only bit zero is kept
                        compat_ff <= pwdata[`COMPAT_BIT];
                    end
                    default: begin
                        // Read-only or unmapped
                        compat_ff <= compat_ff;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Pair prescalers
    // ****************************************************************
    // Divide source clock by prescale plus one
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presc_cnt_ff[0] <= `RST_PRESC;
            presc_cnt_ff[1] <= `RST_PRESC;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (presc_tick[i]) begin
                    // Wrap at terminal count
                    presc_cnt_ff[i] <= `RST_PRESC;
                end else begin
                    // Count source cycles
                    presc_cnt_ff[i] <= presc_cnt_ff[i] + 8'h01;
                end
            end
        end
    end

    assign presc_tick[0] = (presc_cnt_ff[0] >= presc_ff[0]);
    assign presc_tick[1] = (presc_cnt_ff[1] >= presc_ff[1]);

    // ****************************************************************
    // Channels
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
            // One channel, fed by its pair's prescaler
            pwm_channel_core u_core (
                .clk_sys     (clk_sys),
                .rst         (rst),
                .run         (run_ff[g]),
                .presc_tick  (presc_tick[g/2]),
                .div_sel     (div_ff[g]),
                .reload_val  (rld_ff[g]),
                .compare_val (cmp_ff[g]),
                .count_val   (cnt_val[g]),
                .pwm_out     (pwm_out[g])
            );
        end
    endgenerate

endmodule // pwm_duty_compare_readback

// ===== pwm_duty_compare_readback_assertions.sv
// Purpose: Port-level checks for the PWM compare and readback block
// Assumes: One clock domain, zero wait-state APB slave
// Notes:   Bound to the top module, sees its ports only
`timescale 1ns/10ps
`include "pwm_defines.vh"

module pwm_dcr_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  pwm_out,
    input wire logic        compat_mode_bit
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    wire  mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFS_COMPAT); // Every word up to compat
    wire  wr_c   = psel && penable && pwrite && pready && (paddr == `OFS_COMPAT); // Compat write
    logic wbit_ff;                                                 // Last written compat bit

    // Track the compat bit software last wrote
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wbit_ff <= 1'h0;
        end else if (wr_c) begin
            wbit_ff <= pwdata[0];
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    AST_ERR_DATA: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RSVD: assert property (pready && !pwrite && mapped |-> prdata[31:16] == 16'h0)
        else $error("reserved bits not zero");
    AST_COMPAT_RD: assert property (pready && !pwrite && paddr == `OFS_COMPAT
        |-> prdata == {31'h0, compat_mode_bit})
        else $error("compat read differs from pin");
    AST_COMPAT_TRACK: assert property (compat_mode_bit != wbit_ff |-> $past(wr_c))
        else $error("compat pin not following writes");

    cover property (pready && pwrite);
    cover property (pready && !pwrite);
    cover property (pslverr);
    cover property (compat_mode_bit);
endmodule // pwm_dcr_assertions

bind pwm_duty_compare_readback pwm_dcr_assertions pwm_dcr_assertions_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .compat_mode_bit(compat_mode_bit));

// ===== tb.sv
// Purpose: Self-checking bench for the PWM compare and readback block
// Assumes: Prescale at 0x00, divider at 0x04, run bits at 0x08
// Notes:   Reset values and register rows first, then PWM timing and reset cases
`timescale 1ns/10ps
`include "pwm_defines.vh"

module tb;
    // ****************************************************************
    // Signals and tables
    // ****************************************************************
    logic        clk_sys, rst, psel, penable, pwrite; // Bus and clock drives
    logic [7:0]  paddr;                                // Byte address
    logic [31:0] pwdata, rd, s;                        // Write data, read data, saved read
    logic        er;                                   // Error flag of last transfer
    wire  [31:0] prdata;                               // Read data
    wire         pready, pslverr, compat_mode_bit;     // Bus answer, compat pin
    wire  [3:0]  pwm_out;                              // Channel outputs
    int          errors, n_compared, p, h;             // Counters, period and high width
    int          hc [4];                               // High cycles per channel
    int          rl [4] = '{3, 5, 4, 6};               // Reload per channel
    int          cm [4] = '{1, 5, 0, 9};               // Compare per channel
    typedef struct {logic [7:0] a; logic [31:0] w, r; logic e;} row_t;
    row_t rows [9] = '{                                // Address, write, read back, error
        '{`OFS_COMPARE_CH0, 32'hffff_1234, 32'h0000_1234, 1'h0},
        '{`OFS_COMPARE_CH1, 32'h0001_ffff, 32'h0000_ffff, 1'h0},
        '{`OFS_COMPARE_CH2, 32'h0000_0000, 32'h0000_0000, 1'h0},
        '{`OFS_COMPARE_CH3, 32'h8000_8001, 32'h0000_8001, 1'h0},
        '{`OFS_SNAPSHOT_CH3, 32'h0000_5555, 32'h0000_0000, 1'h0},
        '{`OFS_COMPAT, 32'hffff_ffff, 32'h0000_0001, 1'h0},
        '{`OFS_COMPAT, 32'hffff_fffe, 32'h0000_0000, 1'h0},
        '{8'h40, 32'hffff_ffff, 32'h0000_0000, 1'h1},
        '{8'h11, 32'h0000_00ff, 32'h0000_0000, 1'h1}};

    pwm_duty_compare_readback #(.NUM_CH(4)) pwm_duty_compare_readback_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_out(pwm_out), .compat_mode_bit(compat_mode_bit));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Count and report one comparison
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'h1) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        k = 0;
        // Ready and data looked at mid-cycle, where they are settled
        do begin
            @(negedge clk_sys);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        er = pslverr;
        // Hold the request through the edge that commits it
        @(posedge clk_sys);
        psel    <= 1'h0;
        penable <= 1'h0;
        chk(k < 20, "no ready");
    endtask

    // Period and high width from one rising edge of a channel
    task automatic per(input int c);
        @(negedge clk_sys);
        while (pwm_out[c] === 1'h1) @(negedge clk_sys);
        while (pwm_out[c] !== 1'h1) @(negedge clk_sys);
        h = 0;
        while (pwm_out[c] === 1'h1) begin
            @(negedge clk_sys);
            h++;
        end
        p = h;
        while (pwm_out[c] !== 1'h1) begin
            @(negedge clk_sys);
            p++;
        end
    endtask

    // All compare, snapshot and compat registers read zero
    task automatic zero_chk;
        for (int c = 0; c < 4; c++) begin
            apb(1'h0, `OFS_COMPARE_CH0 + 8'(12 * c), 32'h0);
            chk(rd === 32'h0, "compare reset");
            apb(1'h0, `OFS_SNAPSHOT_CH0 + 8'(12 * c), 32'h0);
            chk(rd === 32'h0, "snapshot reset");
        end
        apb(1'h0, `OFS_COMPAT, 32'h0);
        chk(rd === 32'h0 && compat_mode_bit === 1'h0, "compat reset");
    endtask

    // Print counts and verdict, then stop
    task automatic finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end

    initial begin
        errors = 0;
        n_compared = 0;
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        zero_chk();
        // Table rows: write, read back, compare error flags
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].w);
            chk(er === rows[i].e, "write error flag");
            apb(1'h0, rows[i].a, 32'h0);
            chk(rd === rows[i].r && er === rows[i].e, "read back");
            if (rows[i].a == `OFS_COMPAT) chk(compat_mode_bit === rows[i].r[0], "compat pin");
        end
        // Four channels at once, high cycles over a common window
        for (int c = 0; c < 4; c++) begin
            apb(1'h1, `OFS_RELOAD_CH0 + 8'(12 * c), 32'(rl[c]));
            apb(1'h1, `OFS_COMPARE_CH0 + 8'(12 * c), 32'(cm[c]));
        end
        apb(1'h1, `OFS_RUN, 32'hf);
        repeat (20) @(posedge clk_sys);
        hc = '{default: 0};
        repeat (420) begin
            @(negedge clk_sys);
            for (int c = 0; c < 4; c++) hc[c] += int'(pwm_out[c] === 1'h1);
        end
        for (int c = 0; c < 4; c++) begin
            chk(hc[c] == (cm[c] >= rl[c] ? 420 : 420 / (rl[c] + 1) * (cm[c] + 1)), "high count");
            apb(1'h0, `OFS_SNAPSHOT_CH0 + 8'(12 * c), 32'h0);
            chk(rd[31:16] === 16'h0 && rd[15:0] <= rl[c], "snapshot range");
        end
        // Live counter moves between two reads
        apb(1'h0, `OFS_SNAPSHOT_CH0, 32'h0);
        s = rd;
        apb(1'h0, `OFS_SNAPSHOT_CH0, 32'h0);
        chk(rd !== s, "counter frozen");
        // Compare written in low phase keeps the running period
        apb(1'h1, `OFS_RELOAD_CH0, 32'd9);
        apb(1'h1, `OFS_COMPARE_CH0, 32'd2);
        repeat (30) @(posedge clk_sys);
        while (pwm_out[0] !== 1'h1) @(posedge clk_sys);
        while (pwm_out[0] === 1'h1) @(posedge clk_sys);
        apb(1'h1, `OFS_COMPARE_CH0, 32'd6);
        per(0);
        chk(h === 3, "old compare kept");
        per(0);
        chk(h === 7 && p === 10, "new compare applied");
        // Prescale and every divider setting
        apb(1'h1, `OFS_PRESCALE, 32'h0000_0301);
        apb(1'h1, `OFS_RELOAD_CH0, 32'd3);
        apb(1'h1, `OFS_COMPARE_CH0, 32'd0);
        for (int d = 0; d < 5; d++) begin
            apb(1'h1, `OFS_DIVIDER, 32'(d));
            per(0);
            per(0);
            chk(p === 8 * (1 << d) && h === 2 * (1 << d), "divided period");
        end
        per(2);
        chk(p === 20 && h === 4, "pair prescale period");
        // Stopped channels go low and hold their counter
        apb(1'h1, `OFS_RUN, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk(pwm_out === 4'h0, "stopped output");
        apb(1'h0, `OFS_SNAPSHOT_CH2, 32'h0);
        s = rd;
        apb(1'h0, `OFS_SNAPSHOT_CH2, 32'h0);
        chk(rd === s, "stopped counter held");
        // Reset in mid-run clears everything
        apb(1'h1, `OFS_COMPAT, 32'h1);
        apb(1'h1, `OFS_RUN, 32'hf);
        repeat (10) @(posedge clk_sys);
        rst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        chk(pwm_out === 4'h0 && compat_mode_bit === 1'h0, "outputs in reset");
        rst <= 1'h0;
        zero_chk();
        finish_test();
    end
endmodule // tb
